// *** design/thss_sequencer.v ***
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "thss_map.vh"
module thss_sequencer #(
	parameter DATA_LEN = 512,
	parameter MAX_SECT = 64
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite slave
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Disk timing and fault
	input wire index_pulse,
	input wire sector_pulse,
	input wire byte_tick,
	input wire hard_err,
	// Header bytes from host memory
	input wire [7:0] hdr_in_data,
	input wire hdr_in_valid,
	output reg hdr_in_ready,
	// Bytes written to disk
	output reg [7:0] disk_wr_data,
	output reg disk_wr_strobe,
	output reg disk_wr_gate,
	// Header bytes read from disk
	input wire [7:0] hdr_rd_data,
	input wire hdr_rd_valid,
	// Header bytes to host memory
	output reg [7:0] dma_wr_data,
	output reg dma_wr_valid,
	input wire dma_wr_ready,
	// Seek and drive control
	input wire drive_buffered,
	input wire [3:0] seek_done,
	input wire recal_done,
	output reg [3:0] seek_req,
	output reg [15:0] seek_cyl,
	output reg drive_select,
	output reg recal_req,
	output reg fault_clear,
	output reg overlap_hold,
	// Completion
	output reg chain_halt,
	output reg pos_writeback,
	output reg done_irq
);
	localparam [7:0] S_IDLE = 8'h01;
	localparam [7:0] S_WIDX = 8'h02;
	localparam [7:0] S_FMT = 8'h04;
	localparam [7:0] S_RD = 8'h08;
	localparam [7:0] S_DMA = 8'h10;
	localparam [7:0] S_SEEK = 8'h20;
	localparam [7:0] S_RST = 8'h40;
	localparam [7:0] S_RSEL = 8'h80;
	localparam [31:0] SEC_LEN_W = DATA_LEN + 12;
	localparam [15:0] SEC_LEN = SEC_LEN_W[15:0];
	localparam DEPTH = MAX_SECT * 4;

	reg [7:0] state_reg;
	reg [31:0] cmd_reg;
	reg [15:0] cyl_reg;
	reg [7:0] stat_lo_reg;
	reg [7:0] stat_hi_reg;
	reg [7:0] phys_cnt_reg;
	reg [7:0] sect_cnt_reg;
	reg [3:0] seek_busy_reg;
	reg [3:0] seek_fin_reg;
	reg [31:0] hdr_buf_reg;
	reg [2:0] hdr_cnt_reg;
	reg [15:0] pos_reg;
	reg sect_act_reg;
	reg [31:0] ecc_reg;
	reg [1:0] rbyte_reg;
	reg [8:0] wptr_reg;
	reg [8:0] rptr_reg;
	reg [7:0] fifo_mem [0:DEPTH-1];
	reg aw_reg;
	reg [3:0] awaddr_reg;
	reg w_reg;
	reg [31:0] wdata_reg;
	reg [7:0] byte_out;
	reg [31:0] ecc_next;
	wire [3:0] code = cmd_reg[`THSS_CMD_CODE];
	wire [1:0] drv = cmd_reg[`THSS_CMD_DRV];
	wire wr_go = aw_reg && w_reg && !s_axi_bvalid;
	wire go = wr_go && awaddr_reg == `THSS_CMD_OFS &&
		wdata_reg[`THSS_CMD_GO] && state_reg == S_IDLE;
	wire ovl_ok = cmd_reg[`THSS_CMD_OVL] && !cmd_reg[`THSS_CMD_SEQ] &&
		!cmd_reg[`THSS_CMD_FLOPPY] && drive_buffered &&
		seek_busy_reg == 4'h0;
	integer i;

	// Byte sent to disk and ECC update
	always @* begin
		ecc_next = ecc_reg;
		if (pos_reg < 16'd4)
			byte_out = hdr_buf_reg[31 - 8*pos_reg[1:0] -: 8];
		else if (pos_reg < 16'd8)
			byte_out = ecc_reg[31 - 8*pos_reg[1:0] -: 8];
		else if (pos_reg < SEC_LEN - 16'd4)
			byte_out = 8'h00;
		else
			byte_out = ecc_reg[31 - 8*pos_reg[1:0] -: 8];
		if (pos_reg < 16'd4 || (pos_reg >= 16'd8 &&
			pos_reg < SEC_LEN - 16'd4)) begin
			ecc_next = ecc_reg ^ {byte_out, 24'h000000};
			for (i = 0; i < 8; i = i + 1)
				ecc_next = ecc_next[31] ?
					({ecc_next[30:0], 1'b0} ^ `THSS_ECC_POLY) :
					{ecc_next[30:0], 1'b0};
		end
	end

	// AXI4-Lite slave
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h00000000;
			aw_reg <= 1'b0;
			w_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h00000000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg == `THSS_CMD_OFS ||
					awaddr_reg == `THSS_CYL_OFS ||
					awaddr_reg == `THSS_STAT_OFS ||
					awaddr_reg == `THSS_CNT_OFS) ? 2'b00 : 2'b10;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_reg <= 1'b0;
				w_reg <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
				`THSS_CMD_OFS: s_axi_rdata <= {1'b0, cmd_reg[30:0]};
				`THSS_CYL_OFS: s_axi_rdata <= {16'h0000, cyl_reg};
				`THSS_STAT_OFS: s_axi_rdata <= {seek_fin_reg,
					seek_busy_reg, state_reg == S_IDLE ? 8'h00 : 8'h01,
					stat_hi_reg, stat_lo_reg};
				`THSS_CNT_OFS: s_axi_rdata <= {16'h0000,
					sect_cnt_reg, phys_cnt_reg};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Command sequencer
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= S_IDLE;
			cmd_reg <= `THSS_CMD_RST;
			cyl_reg <= `THSS_CYL_RST;
			stat_lo_reg <= 8'h00;
			stat_hi_reg <= 8'h00;
			phys_cnt_reg <= 8'h00;
			sect_cnt_reg <= 8'h00;
			seek_busy_reg <= 4'h0;
			seek_fin_reg <= 4'h0;
			hdr_buf_reg <= 32'h00000000;
			hdr_cnt_reg <= 3'd0;
			pos_reg <= 16'd0;
			sect_act_reg <= 1'b0;
			ecc_reg <= `THSS_ECC_INIT;
			rbyte_reg <= 2'd0;
			wptr_reg <= 9'd0;
			rptr_reg <= 9'd0;
			hdr_in_ready <= 1'b0;
			disk_wr_data <= 8'h00;
			disk_wr_strobe <= 1'b0;
			disk_wr_gate <= 1'b0;
			dma_wr_data <= 8'h00;
			dma_wr_valid <= 1'b0;
			seek_req <= 4'h0;
			seek_cyl <= 16'h0000;
			drive_select <= 1'b1;
			recal_req <= 1'b0;
			fault_clear <= 1'b0;
			overlap_hold <= 1'b0;
			chain_halt <= 1'b0;
			pos_writeback <= 1'b0;
			done_irq <= 1'b0;
		end else begin
			disk_wr_strobe <= 1'b0;
			seek_req <= 4'h0;
			fault_clear <= 1'b0;
			chain_halt <= 1'b0;
			pos_writeback <= 1'b0;
			done_irq <= 1'b0;
			// Polled seek completion, set wins over software clear
			if (wr_go && awaddr_reg == `THSS_STAT_OFS)
				seek_fin_reg <= (seek_fin_reg & ~wdata_reg[31:28]) |
					(seek_busy_reg & seek_done);
			else
				seek_fin_reg <= seek_fin_reg |
					(seek_busy_reg & seek_done);
			seek_busy_reg <= seek_busy_reg & ~seek_done;
			if (wr_go && awaddr_reg == `THSS_CYL_OFS &&
				state_reg == S_IDLE)
				cyl_reg <= wdata_reg[15:0];
			case (state_reg)
			S_IDLE: begin
				overlap_hold <= 1'b0;
				if (go) begin
					cmd_reg <= wdata_reg;
					stat_lo_reg <= 8'h00;
					stat_hi_reg <= 8'h00;
					phys_cnt_reg <= 8'h00;
					sect_cnt_reg <= 8'h00;
					hdr_cnt_reg <= 3'd0;
					wptr_reg <= 9'd0;
					rptr_reg <= 9'd0;
					rbyte_reg <= 2'd0;
					case (wdata_reg[`THSS_CMD_CODE])
					`THSS_OP_WHDR, `THSS_OP_RHDR: begin
						overlap_hold <= 1'b1;
						hdr_in_ready <= wdata_reg[`THSS_CMD_CODE] ==
							`THSS_OP_WHDR;
						state_reg <= S_WIDX;
					end
					`THSS_OP_SEEK: state_reg <= S_SEEK;
					`THSS_OP_DRST: begin
						drive_select <= 1'b0;
						state_reg <= S_RST;
					end
					default: begin
						stat_lo_reg <= `THSS_ST_DONE | `THSS_ST_ERR;
						stat_hi_reg <= `THSS_CC_BADCMD;
						chain_halt <= 1'b1;
					end
					endcase
				end
			end
			S_WIDX: begin
				if (hdr_in_valid && hdr_in_ready) begin
					hdr_buf_reg <= {hdr_buf_reg[23:0], hdr_in_data};
					hdr_cnt_reg <= hdr_cnt_reg + 3'd1;
					if (hdr_cnt_reg == 3'd3)
						hdr_in_ready <= 1'b0;
				end
				if (index_pulse) begin
					sect_act_reg <= code == `THSS_OP_WHDR;
					disk_wr_gate <= code == `THSS_OP_WHDR;
					pos_reg <= 16'd0;
					ecc_reg <= `THSS_ECC_INIT;
					phys_cnt_reg <= 8'h01;
					state_reg <= code == `THSS_OP_WHDR ? S_FMT : S_RD;
				end
			end
			S_FMT: begin
				if (hdr_in_valid && hdr_in_ready) begin
					hdr_buf_reg <= {hdr_buf_reg[23:0], hdr_in_data};
					hdr_cnt_reg <= hdr_cnt_reg + 3'd1;
					if (hdr_cnt_reg == 3'd3)
						hdr_in_ready <= 1'b0;
				end
				if (sect_act_reg && byte_tick) begin
					disk_wr_data <= byte_out;
					disk_wr_strobe <= 1'b1;
					if (pos_reg == 16'd3)
						hdr_in_ready <= 1'b1;
					if (pos_reg == 16'd3)
						hdr_cnt_reg <= 3'd0;
					ecc_reg <= (pos_reg == 16'd7) ?
						`THSS_ECC_INIT : ecc_next;
					if (pos_reg == SEC_LEN - 16'd1) begin
						sect_act_reg <= 1'b0;
						sect_cnt_reg <= sect_cnt_reg + 8'd1;
					end else
						pos_reg <= pos_reg + 16'd1;
				end
				if (sector_pulse && !index_pulse) begin
					phys_cnt_reg <= phys_cnt_reg + 8'd1;
					sect_act_reg <= 1'b1;
					pos_reg <= 16'd0;
					ecc_reg <= `THSS_ECC_INIT;
				end
				// Overrun, underrun or drive fault are all hard
				if (hard_err || (sector_pulse && (sect_act_reg ||
					hdr_cnt_reg != 3'd4))) begin
					disk_wr_gate <= 1'b0;
					hdr_in_ready <= 1'b0;
					stat_lo_reg <= `THSS_ST_DONE | `THSS_ST_ERR;
					stat_hi_reg <= `THSS_CC_HARD;
					chain_halt <= 1'b1;
					done_irq <= cmd_reg[`THSS_CMD_IEN];
					state_reg <= S_IDLE;
				end else if (index_pulse && !sect_act_reg) begin
					disk_wr_gate <= 1'b0;
					hdr_in_ready <= 1'b0;
					stat_lo_reg <= `THSS_ST_DONE;
					stat_hi_reg <= `THSS_CC_OK;
					done_irq <= cmd_reg[`THSS_CMD_IEN];
					state_reg <= S_IDLE;
				end
			end
			S_RD: begin
				if (sector_pulse && !index_pulse)
					phys_cnt_reg <= phys_cnt_reg + 8'd1;
				// Missing address mark means no bytes arrive
				if (hdr_rd_valid) begin
					fifo_mem[wptr_reg[7:0]] <= hdr_rd_data;
					wptr_reg <= wptr_reg + 9'd1;
					rbyte_reg <= rbyte_reg + 2'd1;
					if (rbyte_reg == 2'd3)
						sect_cnt_reg <= sect_cnt_reg + 8'd1;
				end
				if (hard_err || (hdr_rd_valid && wptr_reg == DEPTH)) begin
					stat_lo_reg <= `THSS_ST_DONE | `THSS_ST_ERR;
					stat_hi_reg <= `THSS_CC_HARD;
					chain_halt <= 1'b1;
					done_irq <= cmd_reg[`THSS_CMD_IEN];
					state_reg <= S_IDLE;
				end else if (index_pulse)
					state_reg <= S_DMA;
			end
			S_DMA: begin
				if (dma_wr_valid && dma_wr_ready)
					dma_wr_valid <= 1'b0;
				if ((!dma_wr_valid || dma_wr_ready) &&
					rptr_reg != {sect_cnt_reg, 2'b00}) begin
					dma_wr_data <= fifo_mem[rptr_reg[7:0]];
					dma_wr_valid <= 1'b1;
					rptr_reg <= rptr_reg + 9'd1;
				end else if (!dma_wr_valid ||
					dma_wr_ready) begin
					stat_lo_reg <= `THSS_ST_DONE;
					stat_hi_reg <= `THSS_CC_OK;
					pos_writeback <= cmd_reg[`THSS_CMD_AUD];
					done_irq <= cmd_reg[`THSS_CMD_IEN];
					state_reg <= S_IDLE;
				end
			end
			S_SEEK: begin
				if (!seek_busy_reg[drv] && !seek_req[drv]) begin
					seek_req[drv] <= 1'b1;
					seek_cyl <= cyl_reg;
					seek_busy_reg[drv] <= 1'b1;
					if (ovl_ok) begin
						stat_lo_reg <= `THSS_ST_DONE;
						pos_writeback <= cmd_reg[`THSS_CMD_AUD];
						state_reg <= S_IDLE;
					end
				end else if (seek_done[drv]) begin
					stat_lo_reg <= `THSS_ST_DONE;
					stat_hi_reg <= `THSS_CC_OK;
					pos_writeback <= cmd_reg[`THSS_CMD_AUD];
					done_irq <= cmd_reg[`THSS_CMD_IEN];
					state_reg <= S_IDLE;
				end
			end
			S_RST: begin
				drive_select <= 1'b1;
				recal_req <= 1'b1;
				fault_clear <= 1'b1;
				seek_cyl <= 16'h0000;
				state_reg <= S_RSEL;
			end
			S_RSEL: begin
				if (recal_done) begin
					recal_req <= 1'b0;
					stat_lo_reg <= `THSS_ST_DONE;
					stat_hi_reg <= `THSS_CC_OK;
					done_irq <= cmd_reg[`THSS_CMD_IEN];
					state_reg <= S_IDLE;
				end
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule // thss_sequencer

// *** inc/thss_map.vh ***
`ifndef THSS_MAP_VH
`define THSS_MAP_VH
// Register byte offsets
`define THSS_CMD_OFS 4'h0
`define THSS_CYL_OFS 4'h4
`define THSS_STAT_OFS 4'h8
`define THSS_CNT_OFS 4'hC
// Command register fields
`define THSS_CMD_CODE 3:0
`define THSS_CMD_AUD 4
`define THSS_CMD_IEN 5
`define THSS_CMD_SEQ 6
`define THSS_CMD_OVL 7
`define THSS_CMD_FLOPPY 8
`define THSS_CMD_DRV 10:9
`define THSS_CMD_GO 31
// Command codes
`define THSS_OP_WHDR 4'h3
`define THSS_OP_RHDR 4'h4
`define THSS_OP_SEEK 4'h5
`define THSS_OP_DRST 4'h6
// Spare and bad header fill patterns
`define THSS_HDR_SPARE 8'hDD
`define THSS_HDR_BAD 8'hEE
// Status byte values
`define THSS_ST_DONE 8'h80
`define THSS_ST_ERR 8'h40
`define THSS_CC_OK 8'h00
`define THSS_CC_HARD 8'h21
`define THSS_CC_BADCMD 8'h22
// ECC, 32 bits
`define THSS_ECC_INIT 32'hFFFFFFFF
`define THSS_ECC_POLY 32'h04C11DB7
// Reset values
`define THSS_CMD_RST 32'h00000000
`define THSS_CYL_RST 16'h0000
`endif

// *** test/thss_drive_model.sv ***
`timescale 1ns/10ps
module thss_drive_model (
	// Clock and reset
	input logic aclk,
	input logic aresetn,
	// Drive control
	input logic [3:0] seek_req,
	input logic recal_req,
	output logic [3:0] seek_done,
	output logic recal_done,
	// Host header source and sink
	output logic [7:0] hdr_in_data,
	output logic hdr_in_valid,
	input logic hdr_in_ready,
	input logic [7:0] dma_wr_data,
	input logic dma_wr_valid,
	output logic dma_wr_ready
);
	logic [7:0] src [0:15];
	logic [7:0] sink [0:15];
	logic [3:0] seek_drv;
	logic stall = 1'h0;
	int src_idx, sink_cnt, seek_cnt, recal_cnt;
	assign hdr_in_data = src[src_idx[3:0]];
	assign dma_wr_ready = !stall;
	always @(posedge aclk) begin
		stall <= !stall;
		seek_done <= 4'h0;
		recal_done <= 1'h0;
		recal_cnt <= recal_req ? recal_cnt + 1 : 0;
		if (!aresetn) begin
			hdr_in_valid <= 1'h0;
			src_idx <= 0;
			sink_cnt <= 0;
			seek_cnt <= 0;
		end else begin
			hdr_in_valid <= 1'h1;
			if (hdr_in_valid && hdr_in_ready)
				src_idx <= src_idx + 1;
			if (dma_wr_valid && dma_wr_ready) begin
				sink[sink_cnt[3:0]] <= dma_wr_data;
				sink_cnt <= sink_cnt + 1;
			end
			if (seek_req != 4'h0) begin
				seek_drv <= seek_req;
				seek_cnt <= 40;
			end else if (seek_cnt > 0) begin
				seek_cnt <= seek_cnt - 1;
				if (seek_cnt == 1)
					seek_done <= seek_drv;
			end
			if (recal_cnt == 30)
				recal_done <= 1'h1;
		end
	end
endmodule // thss_drive_model

// *** test/thss_sequencer_chk.sv ***
`timescale 1ns/10ps
module thss_sequencer_chk (
	// Clock and reset
	input logic aclk,
	input logic aresetn,
	// Observed ports
	input logic s_axi_awready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic byte_tick,
	input logic disk_wr_strobe,
	input logic disk_wr_gate,
	input logic [7:0] dma_wr_data,
	input logic dma_wr_valid,
	input logic dma_wr_ready,
	input logic [3:0] seek_req,
	input logic drive_select,
	input logic recal_req,
	input logic recal_done,
	input logic overlap_hold,
	input logic chain_halt,
	input logic pos_writeback
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_b_stands;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_stands: assert property (p_b_stands) else $error("bvalid dropped");
	property p_r_stands;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_stands: assert property (p_r_stands) else $error("read data moved");
	property p_aw_blocked;
		s_axi_bvalid |-> !s_axi_awready;
	endproperty
	a_aw_blocked: assert property (p_aw_blocked) else $error("awready early");
	property p_strobe;
		disk_wr_strobe |-> $past(byte_tick) && disk_wr_gate;
	endproperty
	a_strobe: assert property (p_strobe) else $error("stray strobe");
	property p_hold;
		disk_wr_gate |-> overlap_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("overlap not held");
	property p_seek;
		seek_req != 4'h0 |=> seek_req == 4'h0;
	endproperty
	a_seek: assert property (p_seek) else $error("seek pulse long");
	property p_desel;
		$fell(drive_select) |=> drive_select ##[0:2] recal_req;
	endproperty
	a_desel: assert property (p_desel) else $error("reselect bad");
	property p_recal;
		recal_req && !recal_done |=> recal_req;
	endproperty
	a_recal: assert property (p_recal) else $error("recal dropped");
	property p_halt;
		chain_halt |-> !pos_writeback [*4];
	endproperty
	a_halt: assert property (p_halt) else $error("update on error");
	property p_dma;
		dma_wr_valid && !dma_wr_ready |=> dma_wr_valid && $stable(dma_wr_data);
	endproperty
	a_dma: assert property (p_dma) else $error("dma byte moved");
endmodule // thss_sequencer_chk
bind thss_sequencer thss_sequencer_chk i_chk (.aclk, .aresetn,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .byte_tick, .disk_wr_strobe,
	.disk_wr_gate, .dma_wr_data, .dma_wr_valid, .dma_wr_ready, .seek_req,
	.drive_select, .recal_req, .recal_done, .overlap_hold, .chain_halt,
	.pos_writeback);

// *** test/thss_sequencer_tb_top.sv ***
`timescale 1ns/10ps
`include "thss_map.vh"
module thss_sequencer_tb_top;
	logic aclk = 1'h0, aresetn = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, rd;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, drive_buffered = 1'h0;
	logic index_pulse = 1'h0, sector_pulse = 1'h0, byte_tick = 1'h0;
	logic hard_err = 1'h0, hdr_rd_valid = 1'h0;
	logic [7:0] hdr_rd_data = 8'h0;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, hdr_in_valid, hdr_in_ready, disk_wr_strobe;
	wire disk_wr_gate, dma_wr_valid, dma_wr_ready, recal_done, recal_req;
	wire fault_clear, drive_select, overlap_hold, chain_halt;
	wire pos_writeback, done_irq;
	wire [7:0] hdr_in_data, disk_wr_data, dma_wr_data;
	wire [3:0] seek_done, seek_req;
	wire [15:0] seek_cyl;
	int failures = 0, comparisons = 0, wr_cnt = 0, irq_cnt = 0, wb_cnt = 0;
	int halt_cnt = 0, n, b, ib;
	int fault_cnt = 0;
	logic [1:0] rsp;
	logic [31:0] hecc, decc;
	logic [7:0] wr_bytes [0:63];
	logic [3:0] seen_req = 4'h0;
	logic [13:0] rows [0:5];
	thss_sequencer #(.DATA_LEN(8)) i_dut (.*);
	thss_drive_model i_drv (.*);
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		if (disk_wr_strobe === 1'h1) begin
			wr_bytes[wr_cnt[5:0]] <= disk_wr_data;
			wr_cnt <= wr_cnt + 1;
		end
		if (seek_req !== 4'h0)
			seen_req <= seek_req;
		irq_cnt <= irq_cnt + (done_irq === 1'h1);
		wb_cnt <= wb_cnt + (pos_writeback === 1'h1);
		halt_cnt <= halt_cnt + (chain_halt === 1'h1);
		fault_cnt <= fault_cnt + (fault_clear === 1'h1);
	end
	task automatic check(input string what, input logic [31:0] seen, want);
		comparisons++;
		if (seen !== want) begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", what, want, seen);
		end
	endtask
	function automatic logic [31:0] crc(input logic [63:0] v, input int nb);
		crc = `THSS_ECC_INIT;
		for (int j = nb - 1; j >= 0; j--)
			crc = {crc[30:0], 1'b0} ^
				((crc[31] ^ v[j]) ? `THSS_ECC_POLY : 32'h0);
	endfunction
	task automatic report_and_stop;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		input int lag = 0);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= lag == 0;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			lag--;
			if (lag == 0)
				s_axi_bready <= 1'h1;
		end while (s_axi_bvalid !== 1'h1 || s_axi_bready !== 1'h1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic axi_rd(input logic [3:0] a, input int lag = 0);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= lag == 0;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			lag--;
			if (lag == 0)
				s_axi_rready <= 1'h1;
		end while (s_axi_rvalid !== 1'h1 || s_axi_rready !== 1'h1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic wait_idle(input logic [31:0] mask);
		n = 0;
		do begin
			axi_rd(`THSS_STAT_OFS);
			n++;
		end while ((rd & mask) !== 32'h0 && n < 400);
		if ((rd & mask) !== 32'h0) begin
			failures++;
			report_and_stop;
		end
	endtask
	task automatic pulse(input logic idx);
		index_pulse <= idx;
		sector_pulse <= !idx;
		@(posedge aclk);
		index_pulse <= 1'h0;
		sector_pulse <= 1'h0;
		repeat (3) @(posedge aclk);
	endtask
	task automatic ticks(input int cnt);
		repeat (cnt) begin
			byte_tick <= 1'h1;
			@(posedge aclk);
			byte_tick <= 1'h0;
			repeat (3) @(posedge aclk);
		end
	endtask
	task automatic start_wh(input logic [31:0] cmd);
		i_drv.src_idx = 0;
		axi_wr(`THSS_CMD_OFS, cmd);
		for (int k = 0; k < 50 && i_drv.src_idx < 4; k++)
			@(posedge aclk);
		check("prefetch", i_drv.src_idx, 4);
		pulse(1'h1);
	endtask
	task automatic hdr_bytes(input logic [7:0] v);
		for (int k = 0; k < 4; k++) begin
			hdr_rd_data <= v + k[7:0];
			hdr_rd_valid <= 1'h1;
			@(posedge aclk);
		end
		hdr_rd_valid <= 1'h0;
		hdr_rd_data <= ~v;
		@(posedge aclk);
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		report_and_stop;
	end
	initial begin
		rows = '{{12'h285, 2'h2}, {12'h4C5, 2'h3}, {12'h785, 2'h3},
			{12'h005, 2'h3}, {12'h285, 2'h1}, {12'h006, 2'h3}};
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		axi_rd(`THSS_CMD_OFS);
		check("cmd rst", rd, `THSS_CMD_RST);
		axi_rd(`THSS_CYL_OFS, 3);
		check("cyl rst", rd[15:0], `THSS_CYL_RST);
		check("rresp", rsp, 2'h0);
		axi_wr(4'h2, 32'h0, 3);
		check("bresp bad", rsp, 2'h2);
		axi_rd(4'h2, 3);
		check("rresp bad", rsp, 2'h2);
		check("rdata bad", rd, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			drive_buffered <= rows[i][1];
			axi_wr(`THSS_CYL_OFS, 32'h100 + i);
			axi_wr(`THSS_CMD_OFS, {20'h80000, rows[i][13:2]});
			check("bresp", rsp, 2'h0);
			repeat (8) @(posedge aclk);
			axi_rd(`THSS_STAT_OFS);
			check("busy", rd[23:16], rows[i][0]);
			wait_idle(32'h0FFF0000);
			check("done", rd[15:0], 16'h0080);
			if (rows[i][5:2] == 4'h5)
				check("drive", seen_req, 4'h1 << rows[i][12:11]);
			check("cyl", seek_cyl,
				rows[i][5:2] == 4'h6 ? 0 : 32'h100 + i);
			if (rows[i][5:2] == 4'h6)
				check("fault", fault_cnt, 1);
		end
		$display("test seek table done");
		i_drv.src = '{0:8'h12, 1:8'h34, 2:8'h05, 3:8'h00,
			default:8'hDD};
		hecc = crc(64'h12340500, 32);
		decc = crc(64'h0, 64);
		b = wr_cnt;
		ib = irq_cnt;
		start_wh(32'h80000023);
		ticks(20);
		pulse(1'h0);
		ticks(20);
		pulse(1'h1);
		wait_idle(32'h00FF0000);
		check("status", rd[15:0], 16'h0080);
		check("irq", irq_cnt - ib, 1);
		check("bytes", wr_cnt - b, 40);
		for (int k = 0; k < 8; k++) begin
			check("fill", wr_bytes[b + 8 + k], 8'h00);
			if (k < 4) begin
				check("hdr0", wr_bytes[b + k],
					32'h12340500 >> (24 - 8 * k) & 8'hFF);
				check("hecc", wr_bytes[b + 4 + k],
					hecc[31 - 8 * k -: 8]);
				check("decc", wr_bytes[b + 16 + k],
					decc[31 - 8 * k -: 8]);
				check("hdr1", wr_bytes[b + 20 + k], `THSS_HDR_SPARE);
			end
		end
		$display("test write headers done");
		i_drv.src = '{default:8'hEE};
		b = halt_cnt;
		ib = wb_cnt;
		start_wh(32'h80000013);
		ticks(6);
		hard_err <= 1'h1;
		@(posedge aclk);
		hard_err <= 1'h0;
		wait_idle(32'h00FF0000);
		check("code", rd[15:8], `THSS_CC_HARD);
		check("err", rd[6], 1'h1);
		check("halt", halt_cnt - b, 1);
		check("wb", wb_cnt - ib, 0);
		$display("test hard error done");
		i_drv.sink_cnt = 0;
		ib = irq_cnt;
		axi_wr(`THSS_CMD_OFS, 32'h80000024);
		repeat (4) @(posedge aclk);
		pulse(1'h1);
		hdr_bytes(8'hA0);
		pulse(1'h0);
		pulse(1'h0);
		hdr_bytes(8'hC0);
		check("early", i_drv.sink_cnt, 0);
		pulse(1'h1);
		check("hold", overlap_hold, 1'h1);
		wait_idle(32'h00FF0000);
		check("dma n", i_drv.sink_cnt, 8);
		for (int k = 0; k < 8; k++)
			check("dma", i_drv.sink[k], (k < 4 ? 8'hA0 : 8'hBC) + k);
		axi_rd(`THSS_CNT_OFS);
		check("count", rd[7:0], 8'h03);
		check("xfer", rd[15:8], 8'h02);
		check("irq", irq_cnt - ib, 1);
		$display("test read headers done");
		report_and_stop;
	end
endmodule // thss_sequencer_tb_top
